// ### sah_pkg.sv
// Shared constants and types of the converter control block
package sah_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int RES_BITS  = 16;
  localparam int BYTE_BITS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int STATUS_DELAY_NS   = 110;
  localparam int STATUS_DELAY_CYC  = (STATUS_DELAY_NS / CLK_PERIOD_NS) < 1 ?
                                     1 : STATUS_DELAY_NS / CLK_PERIOD_NS;
  localparam int CONV_TIME_US      = 17;
  localparam int CONV_MAX_CYC      = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int DONE_TO_STATUS_NS = 550;
  localparam int DONE_TO_STATUS_CYC = (DONE_TO_STATUS_NS / CLK_PERIOD_NS) < 1 ?
                                      1 : DONE_TO_STATUS_NS / CLK_PERIOD_NS;
  localparam int STROBE_DELAY_NS   = 200;
  localparam int STROBE_DELAY_CYC  = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS;
  localparam int BIT_CYC_DEF       = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser bundle layout and idle values
  localparam int         N_SYNC   = 7;
  localparam int         SY_CS    = 6;
  localparam int         SY_WR    = 5;
  localparam int         SY_RD    = 4;
  localparam int         SY_UBS   = 3;
  localparam int         SY_TCS   = 2;
  localparam int         SY_BIP   = 1;
  localparam int         SY_CMP   = 0;
  localparam logic [6:0] SYNC_RST = 7'h78;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_TAIL,
    ST_LOAD,
    ST_DROP
  } sah_state_e;

endpackage

// ### sah_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sah_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("sah_sync: WIDTH must be at least 1");
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ### sah_sar.sv
// Successive-approximation register with one decision per call
`timescale 1ns/1ps
`default_nettype none
module sah_sar #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Sequencing
  input  wire logic             clear_i,
  input  wire logic             decide_i,
  input  wire logic             comp_i,
  // Trial code, equal to the result after the last decision
  output logic      [WIDTH-1:0] trial_o
);

  logic [WIDTH-1:0] mask_reg;
  logic [WIDTH-1:0] mask_next;
  logic [WIDTH-1:0] trial_next;
  logic [WIDTH-1:0] msb_only;

  initial begin
    if (WIDTH < 2) begin
      $error("sah_sar: WIDTH must be at least 2");
    end
  end

  assign msb_only   = {1'b1, {(WIDTH-1){1'b0}}};
  // Keep or drop the bit under test, then try the next one down
  assign mask_next  = mask_reg >> 1;
  assign trial_next = (comp_i ? trial_o : (trial_o & ~mask_reg)) |
                      mask_next;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mask_reg <= '0;
      trial_o  <= '0;
    end else if (clear_i) begin
      mask_reg <= msb_only;
      trial_o  <= msb_only;
    end else if (decide_i && (mask_reg != '0)) begin
      mask_reg <= mask_next;
      trial_o  <= trial_next;
    end
  end

endmodule
`default_nettype wire

// ### sah_top.sv
// Host interface and sequencer of a 16-bit successive-approximation converter
// Function
// - Reset clears approximation register, output latch and result-valid flag.
// - During reset busy and result-valid read low; conversion is cancelled.
// - Convert and read strobes count only while chip select is low.
// - Convert strobe falling with chip select low starts a conversion.
// - Busy rises shortly after the convert strobe and holds through conversion.
// - Each conversion makes 16 bits and finishes within 17 us.
// - Result-valid is set first; busy drops within 550 ns after.
// - Output latch is separate; old result stays readable during conversion.
// - Result-valid sets whenever a new result enters the output latch.
// - A read with upper byte selected clears result-valid.
// - Lower-byte reads or no read leave result-valid set.
// - A new result overwrites the latch; result-valid stays high.
// - 8-bit port; byte select low gives upper byte, else lower.
// - Port drives only while chip select and read are low.
// - Bits shift out serially with 16 strobe falls 200 ns after.
// - Busy drops only after the last serial strobe fall.
// - Only the internal clock sequences; only the serial strobe leaves.
// - Twos complement select recodes bipolar parallel-port results; else offset/straight.
`timescale 1ns/1ps
`default_nettype none
module sah_top
  import sah_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC_DEF
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Host control pins
  input  wire logic                  cs_n_i,
  input  wire logic                  convert_n_i,
  input  wire logic                  rd_n_i,
  input  wire logic                  upper_byte_select_n_i,
  // Coding straps
  input  wire logic                  twos_complement_select_i,
  input  wire logic                  bipolar_range_i,
  // Analog front end
  input  wire logic                  comparator_i,
  output logic [sah_pkg::RES_BITS-1:0]  trial_code_o,
  // Parallel port
  output logic [sah_pkg::BYTE_BITS-1:0] data_o,
  output logic                       data_oe_o,
  // Flags
  output logic                       busy_o,
  output logic                       result_valid_o,
  // Serial output
  output logic                       serial_data_o,
  output logic                       serial_strobe_o
);

  import sah_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Local sizes
  localparam int CNT_W    = $clog2(BIT_CYCLES + 1);
  localparam int IDX_W    = $clog2(RES_BITS);
  localparam int TMR_W    = $clog2(STROBE_DELAY_CYC + 1);
  localparam int CCNT_W   = $clog2(CONV_MAX_CYC + 2);
  localparam int FALL_W   = $clog2(RES_BITS + 2);
  localparam int BUSY_MAX = STATUS_DELAY_CYC;
  localparam int DROP_MAX = DONE_TO_STATUS_CYC;

  // Whole conversion must fit the conversion time
  initial begin
    if (BIT_CYCLES <= STROBE_DELAY_CYC + 2) begin
      $error("sah_top: BIT_CYCLES too short for the serial strobe");
    end
    if (BIT_CYCLES * RES_BITS + STROBE_DELAY_CYC + 3 > CONV_MAX_CYC) begin
      $error("sah_top: BIT_CYCLES makes conversion too long");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [N_SYNC-1:0] pins_raw;
  logic [N_SYNC-1:0] pins_s;

  assign pins_raw = {cs_n_i, convert_n_i, rd_n_i, upper_byte_select_n_i,
                     twos_complement_select_i, bipolar_range_i, comparator_i};

  sah_sync #(
    .WIDTH   (N_SYNC),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i (pins_raw),
    .sync_o  (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  logic conv_prev_reg;
  logic selected;
  logic start_pulse;
  logic read_active;
  logic upper_read;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      conv_prev_reg <= 1'b1;
    end else begin
      conv_prev_reg <= pins_s[SY_WR];
    end
  end

  assign selected    = !pins_s[SY_CS];
  // Abandons any conversion in progress when issued while busy
  assign start_pulse = selected && conv_prev_reg && !pins_s[SY_WR];
  assign read_active = selected && !pins_s[SY_RD];
  assign upper_read  = read_active && !pins_s[SY_UBS];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  sah_state_e        state_reg;
  sah_state_e        state_next;
  logic [CNT_W-1:0]  cyc_reg;
  logic [CNT_W-1:0]  cyc_next;
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  idx_next;
  logic              decide;
  logic              last_bit;
  logic              latch_load;
  logic              strobe_idle;

  assign decide     = (state_reg == ST_CONV) &&
                      (cyc_reg == CNT_W'(BIT_CYCLES - 1));
  assign last_bit   = idx_reg == IDX_W'(RES_BITS - 1);
  assign latch_load = state_reg == ST_LOAD;

  always_comb begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    idx_next   = idx_reg;
    if (start_pulse) begin
      state_next = ST_CONV;
      cyc_next   = '0;
      idx_next   = '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cyc_next = '0;
        end
        ST_CONV: begin
          if (decide) begin
            cyc_next = '0;
            idx_next = idx_reg + IDX_W'(1);
            if (last_bit) begin
              state_next = ST_TAIL;
            end
          end else begin
            cyc_next = cyc_reg + CNT_W'(1);
          end
        end
        ST_TAIL: begin
          // Hold off completion until the last strobe edge is out
          if (strobe_idle) begin
            state_next = ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_next = ST_DROP;
        end
        ST_DROP: begin
          state_next = ST_IDLE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= '0;
      idx_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
      idx_reg   <= idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Approximation register
  sah_sar #(
    .WIDTH    (RES_BITS)
  ) u_sar (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .clear_i  (start_pulse),
    .decide_i (decide),
    .comp_i   (pins_s[SY_CMP]),
    .trial_o  (trial_code_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  logic             strobe_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;

  assign strobe_idle = (tmr_reg == '0) && !serial_strobe_o;

  always_comb begin
    strobe_next = serial_strobe_o;
    tmr_next    = tmr_reg;
    if (start_pulse) begin
      strobe_next = 1'b0;
      tmr_next    = '0;
    end else if (decide) begin
      strobe_next = 1'b1;
      tmr_next    = TMR_W'(STROBE_DELAY_CYC);
    end else if (tmr_reg != '0) begin
      tmr_next = tmr_reg - TMR_W'(1);
      if (tmr_reg == TMR_W'(1)) begin
        strobe_next = 1'b0;
      end
    end
  end

  // Serial code is the raw register: straight or offset binary only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      serial_data_o   <= 1'b0;
      serial_strobe_o <= 1'b0;
      tmr_reg         <= '0;
    end else begin
      if (decide) begin
        serial_data_o <= pins_s[SY_CMP];
      end
      serial_strobe_o <= strobe_next;
      tmr_reg         <= tmr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch and flags
  logic [RES_BITS-1:0] latch_reg;
  logic [RES_BITS-1:0] coded;
  logic                twos_mode;
  logic                valid_next;
  logic                busy_next;

  // Twos complement differs from offset binary only in the top bit
  assign twos_mode  = pins_s[SY_TCS] && pins_s[SY_BIP];
  assign coded      = {trial_code_o[RES_BITS-1] ^ twos_mode,
                       trial_code_o[RES_BITS-2:0]};
  // A completing result wins over a clearing read in the same cycle
  assign valid_next = latch_load ? 1'b1 :
                      (upper_read ? 1'b0 : result_valid_o);
  assign busy_next  = state_next != ST_IDLE;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      latch_reg      <= '0;
      result_valid_o <= 1'b0;
      busy_o         <= 1'b0;
    end else begin
      if (latch_load) begin
        latch_reg <= coded;
      end
      result_valid_o <= valid_next;
      busy_o         <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port
  logic [BYTE_BITS-1:0] byte_sel;

  assign byte_sel = pins_s[SY_UBS] ? latch_reg[BYTE_BITS-1:0] :
                    latch_reg[RES_BITS-1:BYTE_BITS];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_o    <= byte_sel;
      data_oe_o <= read_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters for checks
  logic [CCNT_W-1:0] conv_cnt_reg;
  logic [FALL_W-1:0] falls_reg;
  logic              fall_now;

  assign fall_now = serial_strobe_o && !strobe_next;

  always_ff @(posedge clk_i) begin
    if (!rstn_i || start_pulse) begin
      conv_cnt_reg <= '0;
      falls_reg    <= '0;
    end else begin
      if (busy_o && (conv_cnt_reg != '1)) begin
        conv_cnt_reg <= conv_cnt_reg + CCNT_W'(1);
      end
      if (fall_now && (falls_reg != '1)) begin
        falls_reg <= falls_reg + FALL_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_flags_low: assert property (
    @(posedge clk_i) !rstn_i |=> (!busy_o && !result_valid_o && !data_oe_o))
    else $error("flags not low after reset");

  a_reset_latch_clear: assert property (
    @(posedge clk_i) !rstn_i |=> (latch_reg == '0))
    else $error("output latch not cleared by reset");

  a_no_cs_ignore: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    pins_s[SY_CS] |=> !data_oe_o &&
      (($past(state_reg) != ST_IDLE) || (state_reg == ST_IDLE)))
    else $error("strobe acted without chip select");

  a_busy_rise: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    start_pulse |-> ##[1:BUSY_MAX] busy_o)
    else $error("busy late after convert strobe");

  a_conv_time: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    conv_cnt_reg <= CCNT_W'(CONV_MAX_CYC))
    else $error("conversion exceeds its time limit");

  a_valid_then_drop: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    latch_load && !start_pulse |=> (result_valid_o && busy_o)
      ##[1:DROP_MAX] (!busy_o || state_reg == ST_CONV))
    else $error("busy did not drop after result valid");

  a_latch_held: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (state_reg == ST_CONV) |=> $stable(latch_reg))
    else $error("output latch changed during conversion");

  a_valid_on_load: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    latch_load |=> result_valid_o && (latch_reg == $past(coded)))
    else $error("result valid not set on new result");

  a_upper_clears: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    upper_read && !latch_load |=> !result_valid_o)
    else $error("upper byte read left result valid set");

  a_lower_keeps: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    result_valid_o && !upper_read |=> result_valid_o)
    else $error("result valid lost without upper read");

  a_byte_select: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    data_oe_o && !$past(pins_s[SY_UBS]) |->
      data_o == $past(latch_reg[RES_BITS-1:BYTE_BITS]))
    else $error("upper byte not presented");

  a_port_float: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !read_active |=> !data_oe_o)
    else $error("port still driven after read strobe");

  a_strobe_delay: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    decide && !start_pulse |=> serial_strobe_o [*4] ##1 !serial_strobe_o)
    else $error("serial strobe fall not 200 ns after bit");

  a_sixteen_falls: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    latch_load |-> (falls_reg == FALL_W'(RES_BITS)) && !serial_strobe_o)
    else $error("conversion completed before 16 strobe falls");

  a_msb_first: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    start_pulse |=> (trial_code_o == {1'b1, {(RES_BITS-1){1'b0}}}))
    else $error("first trial is not the top bit");

endmodule
`default_nettype wire

// ### sah_far_model.sv
// Far-side model: analog comparator and serial shift register
`timescale 1ns/1ps
`default_nettype none
module sah_far_model (
  // Control from the bench
  input  wire logic        clr_i,
  input  wire logic [15:0] target_i,
  // From the converter
  input  wire logic [15:0] trial_code_i,
  input  wire logic        serial_data_i,
  input  wire logic        serial_strobe_i,
  // To the converter and the bench
  output logic             comparator_o,
  output logic      [15:0] shift_o,
  output logic      [4:0]  edges_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Ideal comparator, so the final trial code equals the target
  assign comparator_o = (target_i >= trial_code_i);

  ////////////////////////////////////////////////////////////////////////////
  // External shift register; the first bit ends up at the top
  always @(negedge serial_strobe_i or posedge clr_i) begin
    if (clr_i) begin
      shift_o <= 16'h0000;
      edges_o <= 5'h00;
    end else begin
      shift_o <= {shift_o[14:0], serial_data_i};
      edges_o <= edges_o + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sah_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        clk_i;
  logic        rstn_i = 1'b0;
  logic        cs_n = 1'b1, conv_n = 1'b1, rd_n = 1'b1, ubs_n = 1'b1;
  logic        tcs = 1'b0, bip = 1'b0, clr = 1'b1;
  logic [15:0] target = 16'h0000;
  logic        comp, busy_o, result_valid_o, data_oe_o, sdata, sstrobe;
  logic [15:0] trial_code_o, shift;
  logic [7:0]  data_o;
  logic [4:0]  edges;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;

  sah_top #(.BIT_CYCLES(8)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .convert_n_i(conv_n),
    .rd_n_i(rd_n), .upper_byte_select_n_i(ubs_n),
    .twos_complement_select_i(tcs), .bipolar_range_i(bip),
    .comparator_i(comp), .trial_code_o(trial_code_o), .data_o(data_o),
    .data_oe_o(data_oe_o), .busy_o(busy_o),
    .result_valid_o(result_valid_o), .serial_data_o(sdata),
    .serial_strobe_o(sstrobe));

  sah_far_model i_far (
    .clr_i(clr), .target_i(target), .trial_code_i(trial_code_o),
    .serial_data_i(sdata), .serial_strobe_i(sstrobe),
    .comparator_o(comp), .shift_o(shift), .edges_o(edges));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a normal run needs about 1250 cycles
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rst();
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk({13'h0, data_oe_o, busy_o, result_valid_o}, 16'h0);
    @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask

  // Chip select is held around the whole strobe, 1 clock before and 3 clocks after
  task automatic start(input logic [15:0] t, input logic sel);
    @(posedge clk_i);
    target <= t;
    clr    <= 1'b1;
    cs_n   <= ~sel;
    @(posedge clk_i);
    clr    <= 1'b0;
    conv_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(16'(busy_o), 16'(sel));
    @(posedge clk_i);
    conv_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs_n   <= 1'b1;
  endtask

  // 340 clocks of 50 ns is the 17 us conversion limit
  task automatic finish_conv(input logic [15:0] raw, input logic full);
    int   n;
    logic v;
    v = 1'b0;
    for (n = 0; n < 340; n++) begin
      @(posedge clk_i);
      #1;
      if (busy_o !== 1'b1) break;
      v = result_valid_o;
    end
    chk(16'(n < 330), 16'h1);
    chk(16'(v), 16'h1);
    chk(16'(result_valid_o), 16'h1);
    chk(trial_code_o, raw);
    if (full) chk({11'h0, edges}, 16'h10);
    if (full) chk(shift, raw);
  endtask

  task automatic rd(input logic up, input logic sel, input logic [7:0] exp);
    @(posedge clk_i);
    ubs_n <= ~up;
    cs_n  <= ~sel;
    rd_n  <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(16'(data_oe_o), 16'(sel));
    if (sel) chk(16'(data_o), 16'(exp));
    @(posedge clk_i);
    rd_n  <= 1'b1;
    cs_n  <= 1'b1;
    ubs_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    chk(16'(data_oe_o), 16'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst();
    start(16'h1234, 1'b0);
    $display("test deselected convert done");
    start(16'h1234, 1'b1);
    finish_conv(16'h1234, 1'b1);
    rd(1'b0, 1'b1, 8'h34);
    chk(16'(result_valid_o), 16'h1);
    rd(1'b1, 1'b0, 8'h00);
    chk(16'(result_valid_o), 16'h1);
    rd(1'b1, 1'b1, 8'h12);
    chk(16'(result_valid_o), 16'h0);
    $display("test basic read done");
    start(16'habcd, 1'b1);
    rd(1'b1, 1'b1, 8'h12);
    finish_conv(16'habcd, 1'b1);
    $display("test old word done");
    // Only the first pass overwrites an unread result; every strap pair is covered
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      tcs <= m[0];
      bip <= m[1];
      start(16'h8001 + 16'(m), 1'b1);
      finish_conv(16'h8001 + 16'(m), 1'b1);
      rd(1'b0, 1'b1, 8'h01 + 8'(m));
      rd(1'b1, 1'b1, (m == 3) ? 8'h00 : 8'h80);
    end
    $display("test coding modes done");
    start(16'h0f0f, 1'b1);
    // Restart lands between two strobe pulses, not inside one
    repeat (42) @(posedge clk_i);
    start(16'h5a5a, 1'b1);
    finish_conv(16'h5a5a, 1'b0);
    rd(1'b0, 1'b1, 8'h5a);
    $display("test abandon done");
    start(16'h7777, 1'b1);
    repeat (20) @(posedge clk_i);
    rst();
    rd(1'b0, 1'b1, 8'h00);
    $display("test reset in conversion done");
    final_report();
  end
endmodule
`default_nettype wire
